// File: verilog/usb_token_frame_registers.sv
// usb register block: flags, enables, status, control, address, token and frame high
`timescale 1ns/10ps
`include "usb_regs_map.svh"
module usb_token_frame_registers
  import usb_regs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  int_events,
  input  wire logic [7:0]  err_events,
  input  wire logic [7:0]  transfer_status,
  input  wire sof_event_t  sof_event,
  output logic             token_issue,
  output token_t           token_out,
  output logic [7:0]       control_out,
  output logic [7:0]       device_address_out,
  output logic [7:0]       bdt_pointer_out,
  output logic             irq
);

  logic [7:0] int_flags_ff;
  logic [7:0] int_enables_ff;
  logic [7:0] err_flags_ff;
  logic [7:0] err_enables_ff;
  logic [7:0] control_ff;
  logic [7:0] dev_addr_ff;
  logic [7:0] bdt_ptr_ff;
  logic [2:0] frame_high_ff;
  token_t     token_ff;
  logic       token_issue_ff;
  logic [31:0] prdata_ff;

  logic [15:0] base_addr;
  logic [1:0]  alias_sel;
  logic        wr_strobe;
  logic        rd_strobe;
  logic        addr_ok;
  logic [7:0]  wbyte;

  // write strobes, one for each register that lives in a sub-block, then the read setup strobe and the next read word
  logic        int_flags_clr;
  logic        err_flags_clr;
  logic        int_enables_wr;
  logic        err_enables_wr;
  logic        control_wr;
  logic        dev_addr_wr;
  logic        bdt_ptr_wr;
  logic        rd_setup;
  logic [31:0] nxt_prdata;

  // every implemented field of this block except the 3-bit frame high is one byte wide
  localparam int REG_W = 8;

  assign base_addr = {paddr[15:4], 4'h0};
  assign alias_sel = paddr[3:2];
  assign wbyte     = pwdata[7:0];
  // single-cycle access phase: the slave never inserts wait states
  assign pready    = 1'b1;
  assign wr_strobe = psel & penable & pwrite & addr_ok;
  assign rd_strobe = psel & penable & ~pwrite & addr_ok;
  assign pslverr   = psel & penable & ~addr_ok;

  // decode which offsets exist, including only the alias slots each register has
  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      unique case (base_addr)
        `OFS_INT_FLAGS, `OFS_ERR_FLAGS:
          addr_ok = (alias_sel == `ALIAS_BASE) || (alias_sel == `ALIAS_CLEAR);
        `OFS_XFER_STATUS, `OFS_FRAME_HIGH:
          addr_ok = (alias_sel == `ALIAS_BASE);
        `OFS_INT_ENABLES, `OFS_ERR_ENABLES, `OFS_CONTROL, `OFS_DEV_ADDRESS,
        `OFS_BDT_PTR_LOW, `OFS_TOKEN_CMD:
          addr_ok = 1'b1;
        default:
          addr_ok = 1'b0;
      endcase
    end
  end

  // new value of a plain read/write register under the alias scheme
  function automatic logic [7:0] alias_apply(input logic [7:0] cur, input logic [1:0] sel,
                                             input logic [7:0] wd);
    unique case (sel)
      `ALIAS_BASE:   alias_apply = wd;
      `ALIAS_CLEAR:  alias_apply = cur & ~wd;
      `ALIAS_SET:    alias_apply = cur | wd;
      `ALIAS_INVERT: alias_apply = cur ^ wd;
    endcase
  endfunction

  // the decode already refused alias slots that a register lacks
  assign int_flags_clr  = wr_strobe && (base_addr == `OFS_INT_FLAGS);
  assign err_flags_clr  = wr_strobe && (base_addr == `OFS_ERR_FLAGS);
  assign int_enables_wr = wr_strobe && (base_addr == `OFS_INT_ENABLES);
  assign err_enables_wr = wr_strobe && (base_addr == `OFS_ERR_ENABLES);
  assign control_wr     = wr_strobe && (base_addr == `OFS_CONTROL);
  assign dev_addr_wr    = wr_strobe && (base_addr == `OFS_DEV_ADDRESS);
  assign bdt_ptr_wr     = wr_strobe && (base_addr == `OFS_BDT_PTR_LOW);
  assign rd_setup       = psel && !penable && !pwrite;

  sticky_flag_bank #(
    .WIDTH (REG_W)
  ) int_flags_u (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clr_en   (int_flags_clr),
    .clr_mask (wbyte),
    .events   (int_events),
    .flags    (int_flags_ff)
  );

  sticky_flag_bank #(
    .WIDTH (REG_W)
  ) err_flags_u (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clr_en   (err_flags_clr),
    .clr_mask (wbyte),
    .events   (err_events),
    .flags    (err_flags_ff)
  );

  alias_rw_reg #(
    .WIDTH (REG_W)
  ) int_enables_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (int_enables_wr),
    .sel     (alias_sel),
    .wdata   (wbyte),
    .value   (int_enables_ff)
  );

  alias_rw_reg #(
    .WIDTH (REG_W)
  ) err_enables_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (err_enables_wr),
    .sel     (alias_sel),
    .wdata   (wbyte),
    .value   (err_enables_ff)
  );

  alias_rw_reg #(
    .WIDTH (REG_W)
  ) control_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (control_wr),
    .sel     (alias_sel),
    .wdata   (wbyte),
    .value   (control_ff)
  );

  alias_rw_reg #(
    .WIDTH (REG_W)
  ) dev_addr_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (dev_addr_wr),
    .sel     (alias_sel),
    .wdata   (wbyte),
    .value   (dev_addr_ff)
  );

  alias_rw_reg #(
    .WIDTH (REG_W)
  ) bdt_ptr_u (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr_en   (bdt_ptr_wr),
    .sel     (alias_sel),
    .wdata   (wbyte),
    .value   (bdt_ptr_ff)
  );

  // token register; pid codes are trusted as written by software
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      token_ff <= '0;
    end else if (wr_strobe && base_addr == `OFS_TOKEN_CMD) begin
      token_ff <= token_t'(alias_apply(token_ff, alias_sel, wbyte));
    end
  end

  // a token write in host mode launches one transaction toward the packet engine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      token_issue_ff <= 1'b0;
    end else begin
      token_issue_ff <= wr_strobe && base_addr == `OFS_TOKEN_CMD
                        && control_ff[`CTRL_HOST_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_high_ff <= 3'h0;
    end else if (sof_event.valid) begin
      frame_high_ff <= sof_event.frame_upper_bits;
    end
  end

  // read data is captured in the setup cycle so it stands through the single access cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    if (rd_setup) begin
      unique case (base_addr)
        `OFS_INT_FLAGS:   nxt_prdata = {24'h0, int_flags_ff};
        `OFS_INT_ENABLES: nxt_prdata = {24'h0, int_enables_ff};
        `OFS_ERR_FLAGS:   nxt_prdata = {24'h0, err_flags_ff};
        `OFS_ERR_ENABLES: nxt_prdata = {24'h0, err_enables_ff};
        `OFS_XFER_STATUS: nxt_prdata = {24'h0, transfer_status};
        `OFS_CONTROL:     nxt_prdata = {24'h0, control_ff};
        `OFS_DEV_ADDRESS: nxt_prdata = {24'h0, dev_addr_ff};
        `OFS_BDT_PTR_LOW: nxt_prdata = {24'h0, bdt_ptr_ff};
        `OFS_FRAME_HIGH:  nxt_prdata = {29'h0, frame_high_ff};
        `OFS_TOKEN_CMD:   nxt_prdata = {24'h0, token_ff};
        default:          nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // the word is held between reads; outside an access cycle it is masked off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata             = (rd_strobe) ? prdata_ff : 32'h0000_0000;
  assign token_issue        = token_issue_ff;
  assign token_out          = token_ff;
  assign control_out        = control_ff;
  assign device_address_out = dev_addr_ff;
  assign bdt_pointer_out    = bdt_ptr_ff;
  assign irq = |(int_flags_ff & int_enables_ff) | |(err_flags_ff & err_enables_ff);

endmodule // usb_token_frame_registers

// sticky event flags: a one written clears, an event in the same cycle wins
module sticky_flag_bank
  import usb_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clr_en,
  input  wire logic [WIDTH-1:0] clr_mask,
  input  wire logic [WIDTH-1:0] events,
  output logic      [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_ff;
  logic [WIDTH-1:0] nxt_flags;

  // the set term is or-ed in last so no event is lost to a clear
  always_comb begin
    nxt_flags = flags_ff;
    if (clr_en) begin
      nxt_flags = flags_ff & ~clr_mask;
    end
    nxt_flags = nxt_flags | events;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // events are level per cycle; a held event keeps its flag set
  assign flags = flags_ff;

endmodule // sticky_flag_bank

// read/write register reached through base, clear, set and invert alias slots
module alias_rw_reg
  import usb_regs_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [1:0]       sel,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_ff;
  logic [WIDTH-1:0] nxt_value;

  // alias slots that a register lacks are refused by the address decode, not here
  always_comb begin
    nxt_value = value_ff;
    if (wr_en) begin
      unique case (sel)
        `ALIAS_BASE:   nxt_value = wdata;
        `ALIAS_CLEAR:  nxt_value = value_ff & ~wdata;
        `ALIAS_SET:    nxt_value = value_ff | wdata;
        `ALIAS_INVERT: nxt_value = value_ff ^ wdata;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      value_ff <= '0;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

endmodule // alias_rw_reg

// File: verilog/usb_regs_map.svh
// register offsets, field positions and reset values of the usb register block
`ifndef USB_REGS_MAP_SVH
`define USB_REGS_MAP_SVH
`define OFS_INT_FLAGS     16'h5200
`define OFS_INT_ENABLES   16'h5210
`define OFS_ERR_FLAGS     16'h5220
`define OFS_ERR_ENABLES   16'h5230
`define OFS_XFER_STATUS   16'h5240
`define OFS_CONTROL       16'h5250
`define OFS_DEV_ADDRESS   16'h5260
`define OFS_BDT_PTR_LOW   16'h5270
`define OFS_FRAME_HIGH    16'h5280
`define OFS_TOKEN_CMD     16'h5290
`define ALIAS_BASE        2'h0
`define ALIAS_CLEAR       2'h1
`define ALIAS_SET         2'h2
`define ALIAS_INVERT      2'h3
`define CTRL_HOST_EN_BIT  3
`define PID_SETUP         4'hd
`define PID_IN            4'h9
`define PID_OUT           4'h1
`define RESET_BYTE        8'h00
`endif

// File: verilog/usb_regs_pkg.sv
// types shared by the usb register block
package usb_regs_pkg;
  typedef enum logic [3:0] {
    PID_OUT_T   = 4'h1,
    PID_IN_T    = 4'h9,
    PID_SETUP_T = 4'hd
  } token_pid_t;

  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] endpoint_number;
  } token_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] frame_upper_bits;
  } sof_event_t;
endpackage

// File: test/usb_regs_chk.sv
// port assertions for the usb register block
`timescale 1ns/10ps
`include "usb_regs_map.svh"
module usb_regs_chk
  import usb_regs_pkg::*;
(
  input wire logic        clk_sys, rst_n, psel, penable, pwrite, pslverr, token_issue, irq,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [7:0]  int_events, err_events, control_out,
  input wire token_t      token_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_acc(a); psel && penable && paddr == a; endsequence
  property p_frm; s_acc(`OFS_FRAME_HIGH) |-> prdata[31:3] == '0; endproperty
  a_frm: assert property (p_frm) else $error("frame high upper bits");
  property p_tok; s_acc(`OFS_TOKEN_CMD) |-> prdata[31:8] == '0; endproperty
  a_tok: assert property (p_tok) else $error("token upper bits");
  property p_issue; s_acc(`OFS_TOKEN_CMD) ##0 (pwrite && control_out[`CTRL_HOST_EN_BIT]) |=>
    token_issue && token_out == $past(pwdata[7:0]); endproperty
  a_issue: assert property (p_issue) else $error("token not issued");
  property p_cause; token_issue |-> $past(psel && penable && pwrite); endproperty
  a_cause: assert property (p_cause) else $error("token unasked");
  property p_stat; s_acc(`OFS_XFER_STATUS + 16'h4) |-> pslverr; endproperty
  a_stat: assert property (p_stat) else $error("status alias");
  property p_flag; s_acc(`OFS_INT_FLAGS + 16'h8) |-> pslverr; endproperty
  a_flag: assert property (p_flag) else $error("flag set alias");
  property p_clr; s_acc(`OFS_CONTROL + 16'h4) ##0 pwrite |=>
    control_out == ($past(control_out) & ~$past(pwdata[7:0])); endproperty
  a_clr: assert property (p_clr) else $error("clear alias");
  property p_irq; $rose(irq) |-> $past(|{int_events, err_events} || penable); endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule // usb_regs_chk
bind usb_token_frame_registers usb_regs_chk chk_u (.*);

// File: test/usb_far_end.sv
// far end of the usb link: event pulses and start-of-frame tokens
`timescale 1ns/10ps
module usb_far_end
  import usb_regs_pkg::*;
(
  input  wire logic  clk_sys,
  output sof_event_t sof_event = '0,
  output logic [7:0] int_events = '0, err_events = '0
);
  task automatic pulse(input logic [7:0] i, e);
    @(posedge clk_sys);
    {int_events, err_events} <= {i, e};
    @(posedge clk_sys);
    {int_events, err_events} <= 16'h0;
    @(posedge clk_sys);
  endtask
  // idle frame bits show garbage so a stale load is caught
  task automatic sof(input logic [2:0] f);
    @(posedge clk_sys);
    sof_event <= {1'b1, f};
    @(posedge clk_sys);
    sof_event <= {1'b0, ~f};
  endtask
endmodule // usb_far_end

// File: test/tb.sv
// usb register block bench
`timescale 1ns/10ps
`include "usb_regs_map.svh"
module tb
  import usb_regs_pkg::*;
;
  logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, token_issue, irq;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0]  int_events, err_events, control_out;
  logic [7:0]  device_address_out, bdt_pointer_out;
  sof_event_t  sof_event;
  token_t      token_out;
  int          num_errors = 0, check_count = 0;
  logic [3:0]  pids [3] = '{`PID_SETUP, `PID_IN, `PID_OUT};
  always #2 clk_sys = ~clk_sys;
  usb_far_end far_u (.*);
  usb_token_frame_registers dut_u (.*, .transfer_status(8'h5c));
  task automatic chk(input logic [31:0] g, x);
    check_count++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, x,
                     input logic e = 0);
    int n = 0;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 9);
    chk(pready, 1'b1);
    if (!w) chk(prdata, x);
    chk(pslverr, e);
    {psel, penable} <= 2'h0;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      acc(0, `OFS_INT_FLAGS + 16'(i * 16), 0, (i == 4) ? 32'h5c : 32'h0);
    end
    acc(0, 16'h5300, 0, 0, 1);
    $display("test reset done");
    acc(1, `OFS_CONTROL, 8'h0f, 0);
    acc(1, `OFS_CONTROL + 16'h4, 8'h03, 0);
    acc(1, `OFS_CONTROL + 16'h8, 8'h30, 0);
    acc(1, `OFS_CONTROL + 16'hc, 8'h0f, 0);
    acc(0, `OFS_CONTROL, 0, 8'h33);
    acc(1, `OFS_DEV_ADDRESS, 8'h5a, 0);
    acc(1, `OFS_BDT_PTR_LOW + 16'hc, 8'h81, 0);
    @(negedge clk_sys);
    chk(device_address_out, 8'h5a);
    chk(bdt_pointer_out, 8'h81);
    acc(1, `OFS_TOKEN_CMD, 8'h91, 0);
    @(negedge clk_sys);
    chk(token_issue, 0);
    acc(1, `OFS_INT_FLAGS + 16'h8, 1, 0, 1);
    acc(1, `OFS_XFER_STATUS + 16'h4, 1, 0, 1);
    acc(0, `OFS_XFER_STATUS, 0, 8'h5c);
    $display("test alias done");
    far_u.pulse(8'h20, 8'h00);
    chk(irq, 0);
    acc(1, `OFS_ERR_ENABLES, 8'h01, 0);
    far_u.pulse(8'h04, 8'h01);
    chk(irq, 1);
    acc(0, `OFS_INT_FLAGS, 0, 8'h24);
    acc(1, `OFS_ERR_FLAGS + 16'h4, 8'h01, 0);
    @(negedge clk_sys);
    chk(irq, 0);
    acc(1, `OFS_INT_ENABLES, 8'h20, 0);
    @(negedge clk_sys);
    chk(irq, 1);
    acc(1, `OFS_INT_FLAGS, 8'h24, 0);
    acc(0, `OFS_INT_FLAGS, 0, 8'h00);
    chk(irq, 0);
    far_u.sof(3'h5);
    acc(0, `OFS_FRAME_HIGH, 0, 8'h05);
    acc(1, `OFS_CONTROL + 16'h8, 8'h08, 0);
    foreach (pids[k]) begin
      acc(1, `OFS_TOKEN_CMD, {pids[k], 4'(k)}, 0);
      @(negedge clk_sys);
      chk(token_issue, 1);
      chk(token_out, {pids[k], 4'(k)});
      acc(0, `OFS_TOKEN_CMD, 0, {pids[k], 4'(k)});
    end
    $display("test token done");
    wrap_up;
  end
  initial begin
    #4000;
    num_errors++;
    wrap_up;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule // tb
